// >>> gh_ctrl.sv
// Bus controller for an IEEE 488 instrument bus: talker, listener,
// ATN/IFC/REN driver, with a small register port for software.
// Assumes bus inputs already synchronous to I_CORE_CLK and an outside
// wired-AND that resolves each line from the enables.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gh_map.svh"

module gh_ctrl import gh_pkg::*; #(
    parameter int IFC_CYCLES = `GH_IFC_CYC
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    // Software register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // Bus lines: sensed level, driven level, drive enable
    input wire gh_lines_type I_GPIB,
    output gh_lines_type O_GPIB,
    output gh_lines_type O_GPIB_OE
);
    logic ctrl_ren_q, ctrl_atn_q, ctrl_lsn_q, atn_q;
    logic tx_pend_q, tx_eoi_q;
    logic [7:0] tx_byte_q;
    logic [7:0] rx_byte_q;
    logic rx_end_q, rx_vld_q, inv_q;
    logic [31:0] rdata_q;
    gh_src_state_type src_q;
    gh_acc_state_type acc_q;
    logic wr_ctrl, wr_tx, wr_stat, rd_rx;
    logic src_go, atn_chg, settle_busy, ifc_busy, ifc_start;
    logic listening, take_byte, bad_lines;

    // Register select on the software port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // Address and command byte coding for the transmit register
    function automatic logic [7:0] code_byte(input logic [31:0] wd);
        logic [1:0] k;
        k = wd[`GH_TX_KIND_HI:`GH_TX_KIND_LO];
        case (k)
            `GH_KIND_LSN: code_byte = `GH_BASE_LSN | {3'h0, wd[4:0]};
            `GH_KIND_TLK: code_byte = `GH_BASE_TLK | {3'h0, wd[4:0]};
            `GH_KIND_SEC: code_byte = `GH_BASE_SEC | {3'h0, wd[4:0]};
            default: code_byte = wd[7:0];
        endcase
    endfunction : code_byte

    // Strobe decode
    assign wr_ctrl = I_WR && hit(I_ADDR, `GH_REG_CTRL);
    assign wr_tx = I_WR && hit(I_ADDR, `GH_REG_TX);
    assign wr_stat = I_WR && hit(I_ADDR, `GH_REG_STAT);
    assign rd_rx = I_RD && hit(I_ADDR, `GH_REG_RX);

    // Sequencing terms
    assign ifc_start = wr_ctrl && I_WDATA[`GH_CTRL_IFC] && !ifc_busy;
    assign atn_chg = (src_q == SRC_IDLE) && (atn_q != ctrl_atn_q);
    assign src_go = (src_q == SRC_IDLE) && tx_pend_q && !ifc_busy &&
        (acc_q == ACC_OFF) && !atn_chg;
    assign listening = ctrl_lsn_q && !atn_q && !ifc_busy &&
        (src_q == SRC_IDLE) && !tx_pend_q;
    assign take_byte = (acc_q == ACC_RDY) && !I_GPIB.dav_n;
    assign bad_lines = (src_q == SRC_RFD) && I_GPIB.nrfd_n &&
        I_GPIB.ndac_n;

    // Settling time after a new byte or an ATN change
    gh_timer #(
        .CYCLES(16'(`GH_SETTLE_CYC))
    ) u_settle (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_start(src_go || atn_chg),
        .o_busy(settle_busy)
    );

    // Interface clear pulse width
    gh_timer #(
        .CYCLES(16'(IFC_CYCLES))
    ) u_ifc (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_start(ifc_start),
        .o_busy(ifc_busy)
    );

    // Control register
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_ren_q <= 1'b0;
            ctrl_atn_q <= 1'b0;
            ctrl_lsn_q <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_ren_q <= I_WDATA[`GH_CTRL_REN];
            ctrl_atn_q <= I_WDATA[`GH_CTRL_ATN];
            ctrl_lsn_q <= I_WDATA[`GH_CTRL_LSN];
        end
    end

    // ATN follows the request only between source handshakes, never in the middle of a sent byte
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            atn_q <= 1'b0;
        end else if (atn_chg) begin
            atn_q <= ctrl_atn_q;
        end
    end

    // Transmit holding register, one byte outstanding
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_pend_q <= 1'b0;
            tx_byte_q <= 8'h00;
            tx_eoi_q <= 1'b0;
        end else if (ifc_busy) begin
            tx_pend_q <= 1'b0;
        end else if (wr_tx && !tx_pend_q) begin
            tx_pend_q <= 1'b1;
            tx_byte_q <= code_byte(I_WDATA);
            tx_eoi_q <= I_WDATA[`GH_TX_EOI] &&
                (I_WDATA[`GH_TX_KIND_HI:`GH_TX_KIND_LO] == `GH_KIND_DATA);
        end else if ((src_q == SRC_DAV) && I_GPIB.ndac_n) begin
            tx_pend_q <= 1'b0;
        end
    end

    // Source handshake
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            src_q <= SRC_IDLE;
        end else if (ifc_busy) begin
            src_q <= SRC_IDLE;
        end else begin
            case (src_q)
                SRC_IDLE: begin
                    if (src_go) begin
                        src_q <= SRC_RFD;
                    end
                end
                SRC_RFD: begin
                    if (I_GPIB.nrfd_n && !I_GPIB.ndac_n && !settle_busy) begin
                        src_q <= SRC_DAV;
                    end
                end
                SRC_DAV: begin
                    if (I_GPIB.ndac_n) begin
                        src_q <= SRC_IDLE;
                    end
                end
                default: src_q <= SRC_IDLE;
            endcase
        end
    end

    // Acceptor handshake, ready only while the receive word is free
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            acc_q <= ACC_OFF;
        end else if (!listening) begin
            acc_q <= ACC_OFF;
        end else begin
            case (acc_q)
                ACC_OFF: acc_q <= ACC_NRDY;
                ACC_NRDY: begin
                    if (!rx_vld_q && I_GPIB.dav_n) begin
                        acc_q <= ACC_RDY;
                    end
                end
                ACC_RDY: begin
                    if (take_byte) begin
                        acc_q <= ACC_ACC;
                    end
                end
                ACC_ACC: begin
                    if (I_GPIB.dav_n) begin
                        acc_q <= ACC_NRDY;
                    end
                end
                default: acc_q <= ACC_OFF;
            endcase
        end
    end

    // Receive word; a capture beats a clearing read
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_byte_q <= 8'h00;
            rx_end_q <= 1'b0;
            rx_vld_q <= 1'b0;
        end else if (take_byte) begin
            rx_byte_q <= ~I_GPIB.dio_n;
            rx_end_q <= !I_GPIB.eoi_n;
            rx_vld_q <= 1'b1;
        end else if (rd_rx) begin
            rx_vld_q <= 1'b0;
        end
    end

    // Invalid line state, sticky, set wins over write-one clear
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            inv_q <= 1'b0;
        end else if (bad_lines) begin
            inv_q <= 1'b1;
        end else if (wr_stat && I_WDATA[`GH_ST_INV]) begin
            inv_q <= 1'b0;
        end
    end

    // Read data, valid in the cycle after the read strobe only
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= 32'h0000_0000;
            if (I_RD && hit(I_ADDR, `GH_REG_CTRL)) begin
                rdata_q[`GH_CTRL_REN] <= ctrl_ren_q;
                rdata_q[`GH_CTRL_ATN] <= ctrl_atn_q;
                rdata_q[`GH_CTRL_LSN] <= ctrl_lsn_q;
                rdata_q[`GH_CTRL_IFC] <= ifc_busy;
            end else if (rd_rx) begin
                rdata_q[7:0] <= rx_byte_q;
                rdata_q[`GH_RX_END] <= rx_end_q;
                rdata_q[`GH_RX_VLD] <= rx_vld_q;
            end else if (I_RD && hit(I_ADDR, `GH_REG_STAT)) begin
                rdata_q[`GH_ST_BUSY] <= tx_pend_q;
                rdata_q[`GH_ST_RXV] <= rx_vld_q;
                rdata_q[`GH_ST_SRQ] <= !I_GPIB.srq_n;
                rdata_q[`GH_ST_INV] <= inv_q;
                rdata_q[`GH_ST_IFC] <= ifc_busy;
            end
        end
    end

    assign O_RDATA = rdata_q;

    // Line drive: control lines pull low when enabled; enabled DIO lines drive the inverted byte
    always_comb begin
        O_GPIB = '0;
        O_GPIB.dio_n = ~tx_byte_q;
        O_GPIB_OE = '0;
        O_GPIB_OE.dio_n = {8{src_q != SRC_IDLE}};
        O_GPIB_OE.dav_n = (src_q == SRC_DAV);
        O_GPIB_OE.eoi_n = (src_q != SRC_IDLE) && tx_eoi_q && !atn_q;
        O_GPIB_OE.nrfd_n = (acc_q == ACC_NRDY) || (acc_q == ACC_ACC);
        O_GPIB_OE.ndac_n = (acc_q == ACC_NRDY) || (acc_q == ACC_RDY);
        O_GPIB_OE.atn_n = atn_q;
        O_GPIB_OE.ifc_n = ifc_busy;
        O_GPIB_OE.ren_n = ctrl_ren_q;
    end

    // Checks on the driven lines
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    logic [15:0] ifc_len_q;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ifc_len_q <= 16'h0000;
        end else if (O_GPIB_OE.ifc_n) begin
            ifc_len_q <= ifc_len_q + 16'h0001;
        end else begin
            ifc_len_q <= 16'h0000;
        end
    end

    sequence s_dav_fall;
        $rose(O_GPIB_OE.dav_n);
    endsequence
    // Byte already on the lines eight cycles before DAV rises
    sequence s_byte_settled;
        $past(O_GPIB_OE.dio_n, 8) == 8'hFF;
    endsequence

    a_dav_after_data: assert property (
        s_dav_fall |-> s_byte_settled)
        else $error("DAV asserted without a settled byte");
    a_dav_waits_rfd: assert property (
        s_dav_fall |-> $past(I_GPIB.nrfd_n) && !$past(I_GPIB.ndac_n))
        else $error("DAV asserted while not ready or not reset");
    a_dac_release: assert property (
        O_GPIB_OE.dav_n && I_GPIB.ndac_n |=>
            !O_GPIB_OE.dav_n && (O_GPIB_OE.dio_n == 8'h00))
        else $error("DAV or byte kept after data accepted");
    a_settle_wait: assert property (
        $rose(src_q == SRC_RFD) |-> !O_GPIB_OE.dav_n [*8])
        else $error("DAV asserted before the settling time");
    a_nrfd_hold: assert property (
        (acc_q != ACC_OFF) && rx_vld_q |-> O_GPIB_OE.nrfd_n)
        else $error("NRFD released with the receive word full");
    a_ndac_capture: assert property (
        $fell(O_GPIB_OE.ndac_n) && (acc_q == ACC_ACC) |-> rx_vld_q)
        else $error("NDAC released before the byte was captured");
    a_eoi_no_atn: assert property (
        O_GPIB_OE.eoi_n |-> !O_GPIB_OE.atn_n && O_GPIB_OE.dio_n[0])
        else $error("EOI driven with ATN or without data");
    a_atn_between: assert property (
        $changed(O_GPIB_OE.atn_n) |-> $past(src_q) == SRC_IDLE)
        else $error("ATN changed during a handshake");
    a_invalid_flag: assert property (
        bad_lines |=> inv_q)
        else $error("Invalid NRFD and NDAC state not flagged");
    a_ifc_width: assert property (
        $fell(O_GPIB_OE.ifc_n) |-> ifc_len_q >= 16'(IFC_CYCLES))
        else $error("IFC pulse shorter than the minimum");

endmodule : gh_ctrl
`default_nettype wire

// >>> gh_map.svh
// Constants of the bus controller: register offsets, field positions,
// address bases and timing counts.
// Assumes a 100 MHz core clock; included by gh_ctrl.sv.
`ifndef GH_MAP_SVH
`define GH_MAP_SVH

// Register offsets on the software port
`define GH_REG_CTRL 8'h00
`define GH_REG_TX 8'h04
`define GH_REG_RX 8'h08
`define GH_REG_STAT 8'h0C

// CTRL fields
`define GH_CTRL_REN 0
`define GH_CTRL_ATN 1
`define GH_CTRL_LSN 2
`define GH_CTRL_IFC 3

// TX fields: byte in [7:0]
`define GH_TX_EOI 8
`define GH_TX_KIND_LO 9
`define GH_TX_KIND_HI 10

// RX fields: byte in [7:0]
`define GH_RX_END 8
`define GH_RX_VLD 9

// STAT fields
`define GH_ST_BUSY 0
`define GH_ST_RXV 1
`define GH_ST_SRQ 2
`define GH_ST_INV 3
`define GH_ST_IFC 4

// TX kinds and address bases
`define GH_KIND_DATA 2'h0
`define GH_KIND_LSN 2'h1
`define GH_KIND_TLK 2'h2
`define GH_KIND_SEC 2'h3
`define GH_BASE_LSN 8'h20
`define GH_BASE_TLK 8'h40
`define GH_BASE_SEC 8'h60

// Timing
`define GH_CLK_NS 10
`define GH_SETTLE_NS 2000
`define GH_SETTLE_CYC ((`GH_SETTLE_NS + `GH_CLK_NS - 1) / `GH_CLK_NS)
`define GH_IFC_US 100
`define GH_IFC_CYC ((`GH_IFC_US * 1000) / `GH_CLK_NS + 1)

`endif

// >>> gh_pkg.sv
// Types of the bus controller: line bundle and state enumerations.
// Assumes nothing beyond a SystemVerilog compiler.
package gh_pkg;

    // One bit per bus line, all active low as on the wire
    typedef struct packed {
        logic [7:0] dio_n;
        logic eoi_n;
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
        logic atn_n;
        logic ifc_n;
        logic ren_n;
        logic srq_n;
    } gh_lines_type;

    // Source handshake states
    typedef enum logic [1:0] {
        SRC_IDLE,
        SRC_RFD,
        SRC_DAV
    } gh_src_state_type;

    // Acceptor handshake states
    typedef enum logic [1:0] {
        ACC_OFF,
        ACC_NRDY,
        ACC_RDY,
        ACC_ACC
    } gh_acc_state_type;

endpackage : gh_pkg

// >>> gh_timer.sv
// Down-counting hold timer: busy for CYCLES clocks after a start pulse.
// Assumes a single clock domain and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module gh_timer #(
    parameter logic [15:0] CYCLES = 16'h0001
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_start,
    output logic o_busy
);
    logic [15:0] cnt_q;

    // Reload on start, else count down to zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 16'h0000;
        end else if (i_start) begin
            cnt_q <= CYCLES;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign o_busy = (cnt_q != 16'h0000);

endmodule : gh_timer
`default_nettype wire

// >>> gh_dev_model.sv
// Instrument model standing on the far side of the bus controller.
// Assumes the bench resolves each wired-AND line from all pull enables.
`timescale 1ns/1ns
`default_nettype none

module gh_dev_model import gh_pkg::*; #(
    parameter logic [4:0] ADDR = 5'h0C
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Bus: resolved level in, pull-low enables out
    input wire gh_lines_type i_bus,
    output gh_lines_type o_pull,
    // Bench controls
    input wire logic [7:0] i_delay,
    input wire logic [8:0] i_tx,
    input wire logic i_talk_req,
    input wire logic i_srq,
    input wire logic i_local,
    // Observed state: listen, talk, remote, lockout
    output logic [3:0] o_state,
    output logic [8:0] o_rx,
    output logic [7:0] o_rx_cnt
);
    gh_lines_type s1_q;
    gh_lines_type s_q;
    logic [7:0] wait_q;
    logic got_q;
    logic sent_q;
    logic dav_q;
    logic lsn_q;
    logic tlk_q;
    logic rem_q;
    logic lock_q;
    logic cmd;
    logic acc;
    logic src;
    logic cap;
    logic [6:0] b;

    // Two-stage synchroniser on every line
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '1;
            s_q <= '1;
        end else begin
            s1_q <= i_bus;
            s_q <= s1_q;
        end
    end

    // Roles: commands under ATN, data only when addressed
    assign cmd = !s_q.atn_n;
    assign acc = cmd || (lsn_q && s_q.ifc_n);
    assign src = tlk_q && !cmd && s_q.ifc_n && i_talk_req && !sent_q;
    assign cap = acc && !s_q.dav_n && !got_q && wait_q >= i_delay;
    assign b = ~s_q.dio_n[6:0];
    assign o_state = {lsn_q, tlk_q, rem_q, lock_q};

    // Acceptor: capture, after an optional slow delay
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            got_q <= 1'b0;
            wait_q <= 8'h00;
            o_rx <= 9'h000;
            o_rx_cnt <= 8'h00;
        end else if (cap) begin
            got_q <= 1'b1;
            o_rx <= {!s_q.eoi_n && !cmd, ~s_q.dio_n};
            o_rx_cnt <= o_rx_cnt + 8'h01;
        end else if (acc && !s_q.dav_n && !got_q) begin
            wait_q <= wait_q + 8'h01;
        end else if (s_q.dav_n || !acc) begin
            got_q <= 1'b0;
            wait_q <= 8'h00;
        end
    end

    // Source: byte first, DAV once ready, release when accepted
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dav_q <= 1'b0;
            sent_q <= 1'b0;
        end else if (!src) begin
            dav_q <= 1'b0;
            sent_q <= sent_q && i_talk_req;
        end else if (!dav_q && s_q.nrfd_n && !s_q.ndac_n) begin
            dav_q <= 1'b1;
        end else if (dav_q && s_q.ndac_n) begin
            dav_q <= 1'b0;
            sent_q <= 1'b1;
        end
    end

    // Addressing and remote-local state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lsn_q <= 1'b0;
            tlk_q <= 1'b0;
            rem_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            if (!s_q.ifc_n) begin
                lsn_q <= 1'b0;
                tlk_q <= 1'b0;
            end
            if (s_q.ren_n) begin
                rem_q <= 1'b0;
                lock_q <= 1'b0;
            end else if (i_local && !lock_q) begin
                rem_q <= 1'b0;
            end
            if (cap && cmd) begin
                case (b)
                    {2'b01, ADDR}: if (s_q.ifc_n) begin
                        lsn_q <= 1'b1;
                        rem_q <= !s_q.ren_n;
                    end
                    {2'b10, ADDR}: tlk_q <= s_q.ifc_n;
                    7'h3F: lsn_q <= 1'b0;
                    7'h5F: tlk_q <= 1'b0;
                    7'h01: if (lsn_q && s_q.ifc_n) begin
                        rem_q <= 1'b0;
                    end
                    7'h11: lock_q <= !s_q.ren_n;
                    default: ;
                endcase
            end
        end
    end

    // Pull-low enables; released lines float to their pull-ups
    always_comb begin
        o_pull = '0;
        o_pull.dio_n = src ? i_tx[7:0] : 8'h00;
        o_pull.eoi_n = src && i_tx[8];
        o_pull.dav_n = dav_q;
        o_pull.nrfd_n = acc && (got_q || !s_q.dav_n);
        o_pull.ndac_n = acc && !got_q;
        o_pull.srq_n = i_srq;
    end
endmodule : gh_dev_model
`default_nettype wire

// >>> gpib_handshake_remote_local_tb_top.sv
// Self-checking bench of the bus controller facing one instrument model.
// Assumes gh_pkg, gh_ctrl and gh_dev_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "gh_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module gpib_handshake_remote_local_tb_top import gh_pkg::*;;
    localparam int IFC_N = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic srq = 1'b0;
    logic loc = 1'b0;
    logic treq = 1'b0;
    logic dav_p = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] dly = 8'h00;
    logic [8:0] txb = 9'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] s;
    logic [3:0] st;
    logic [8:0] rx;
    logic [7:0] cnt;
    gh_lines_type o_l;
    gh_lines_type oe;
    gh_lines_type pull;
    gh_lines_type bus;
    int n_errors = 0;
    int n_tests = 0;
    int settle = 0;
    int n_ifc = 0;

    // Wired-AND of all parties, pull-ups where released
    assign bus = gh_lines_type'((~oe | o_l) & ~pull);

    gh_ctrl #(.IFC_CYCLES(IFC_N)) dut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_GPIB(bus), .O_GPIB(o_l), .O_GPIB_OE(oe));

    gh_dev_model u_dev (
        .i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_pull(pull),
        .i_delay(dly), .i_tx(txb), .i_talk_req(treq), .i_srq(srq),
        .i_local(loc), .o_state(st), .o_rx(rx), .o_rx_cnt(cnt));

    // Clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Settling, handshake order and line watch
    always @(posedge clk) begin
        if (oe.dav_n && !dav_p) begin
            `CHK(settle >= 200, 1'b1)
            `CHK({bus.nrfd_n, bus.ndac_n}, 2'b10)
        end
        if (oe.eoi_n && oe.atn_n) `CHK(1'b1, 1'b0)
        dav_p <= oe.dav_n;
        settle <= (oe.dio_n != 8'h00) ? settle + 1 : 0;
        n_ifc <= oe.ifc_n ? n_ifc + 1 : n_ifc;
    end

    task automatic wreg(input logic [7:0] a, input logic [11:0] d);
        addr <= a;
        wdata <= {20'h0_0000, d};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg

    task automatic rreg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        s = rdata;
    endtask : rreg

    // Poll status until a bit reaches a value, bounded
    task automatic poll(input int b, input logic v);
        rreg(`GH_REG_STAT);
        for (int i = 0; i < 1000 && s[b] !== v; i++) begin
            rreg(`GH_REG_STAT);
        end
    endtask : poll

    task automatic tx(input logic [1:0] k, input logic [8:0] v);
        wreg(`GH_REG_TX, {1'b0, k, v});
        poll(0, 1'b0);
        `CHK(s[0], 1'b0)
    endtask : tx

    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            if (i != 1) begin
                rreg(8'(i * 4));
                `CHK(s, 32'h0000_0000)
            end
        end
        `CHK(oe, 16'h0000)
        $display("t_reset done");
    endtask : t_reset

    task automatic t_listen();
        wreg(`GH_REG_CTRL, 12'h003);
        tx(`GH_KIND_LSN, 9'h00C);
        `CHK(rx, 9'h02C)
        `CHK(st, 4'b1010)
        tx(`GH_KIND_SEC, 9'h00C);
        `CHK(rx, 9'h06C)
        wreg(`GH_REG_CTRL, 12'h001);
        dly <= 8'd40;
        tx(`GH_KIND_DATA, 9'h041);
        `CHK(rx, 9'h041)
        `CHK(st, 4'b1010)
        tx(`GH_KIND_DATA, 9'h142);
        `CHK(rx, 9'h142)
        `CHK(cnt, 8'd4)
        dly <= 8'd0;
        $display("t_listen done");
    endtask : t_listen

    task automatic t_talk();
        wreg(`GH_REG_CTRL, 12'h003);
        tx(`GH_KIND_DATA, 9'h13F);
        `CHK(rx, 9'h03F)
        `CHK(st, 4'b0010)
        tx(`GH_KIND_TLK, 9'h00C);
        `CHK(st[2], 1'b1)
        txb <= 9'h15A;
        treq <= 1'b1;
        wreg(`GH_REG_CTRL, 12'h005);
        poll(1, 1'b1);
        `CHK(s[1], 1'b1)
        rreg(`GH_REG_RX);
        `CHK(s[9:0], 10'h35A)
        rreg(`GH_REG_RX);
        `CHK(s[9], 1'b0)
        treq <= 1'b0;
        wreg(`GH_REG_CTRL, 12'h003);
        tx(`GH_KIND_DATA, 9'h05F);
        `CHK(st, 4'b0010)
        $display("t_talk done");
    endtask : t_talk

    task automatic t_lock();
        tx(`GH_KIND_DATA, 9'h011);
        tx(`GH_KIND_LSN, 9'h00C);
        loc <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(st, 4'b1011)
        loc <= 1'b0;
        tx(`GH_KIND_DATA, 9'h001);
        `CHK(st, 4'b1001)
        wreg(`GH_REG_CTRL, 12'h002);
        repeat (10) @(posedge clk);
        `CHK(st, 4'b1000)
        wreg(`GH_REG_CTRL, 12'h003);
        repeat (5) @(posedge clk);
        `CHK(st, 4'b1000)
        tx(`GH_KIND_LSN, 9'h00C);
        `CHK(st, 4'b1010)
        loc <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(st, 4'b1000)
        loc <= 1'b0;
        $display("t_lock done");
    endtask : t_lock

    task automatic t_ifc();
        logic [7:0] c;
        tx(`GH_KIND_DATA, 9'h03F);
        wreg(`GH_REG_CTRL, 12'h000);
        c = cnt;
        wreg(`GH_REG_TX, 12'h077);
        repeat (300) @(posedge clk);
        srq <= 1'b1;
        rreg(`GH_REG_STAT);
        `CHK(s[4:0], 5'h0D)
        `CHK(cnt, c)
        srq <= 1'b0;
        wreg(`GH_REG_CTRL, 12'h008);
        rreg(`GH_REG_STAT);
        `CHK(s[4], 1'b1)
        repeat (100) @(posedge clk);
        `CHK(n_ifc, IFC_N)
        rreg(`GH_REG_STAT);
        `CHK(s[4:0], 5'h08)
        wreg(`GH_REG_STAT, 12'h008);
        rreg(`GH_REG_STAT);
        `CHK(s[3], 1'b0)
        $display("t_ifc done");
    endtask : t_ifc

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_listen();
        t_talk();
        t_lock();
        t_ifc();
        test_done();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule : gpib_handshake_remote_local_tb_top
`default_nettype wire
